//--- core/fvr_pkg.sv
// constants shared by the feature and product-data rom space
// assumes a host that reads the space by byte address relative to its base
//
// Notes on behaviour
// - word at base is the 32-bit device identity word, device-id layout.
// - minimal form characteristics word reads all zero.
// - minimal form holds 248 data bytes at locations two through sixty-three.
// - standard characteristics word is zero above, object count in low byte.
// - object count nonzero, sum of three counts, architected count one or two.
// - length word upper half gives rom size in 512-byte units.
// - length word lower half is crc over location three to last byte.
// - unused bytes of the last 512-byte unit read zero.
// - rom size stays below space length divided by word increment.
// - descriptor array starts at location three, three words per object.
// - descriptor word 0 holds three scope flags, zero bits, 16-bit block id.
// - descriptor word 1 is block byte offset, word 2 is block length.
// - blocks start after array, at or beyond (3n+4) increments, 8-byte aligned.
// - scan header holds length and first-block offset, checksummed contiguously.
// - increment field 000 means 4-byte spacing, 001 means 8-byte spacing.
// - indicator 10 means one byte per location, 11 a full word.

package fvr_pkg;

	// ------------------------------------------------------------
	// space geometry
	// ------------------------------------------------------------
	localparam int          SPACE_LEN  = 32'h0020_0000; // architected space length in bytes
	localparam int          UNIT_BYTES = 512;
	localparam int          UNIT_WORDS = 128;
	localparam logic [2:0]  INC_4      = 3'h0;
	localparam logic [2:0]  INC_8      = 3'h1;
	localparam logic [1:0]  IND_BYTE   = 2'h2;
	localparam logic [1:0]  IND_WORD   = 2'h3;

	// ------------------------------------------------------------
	// content word indexes
	// ------------------------------------------------------------
	localparam logic [20:0] W_DEVID    = 21'h0_0000;
	localparam logic [20:0] W_CHAR     = 21'h0_0001;
	localparam logic [20:0] W_LENCRC   = 21'h0_0002;
	localparam int          W_ARRAY    = 3;
	localparam int          MIN_FIRST  = 2;
	localparam int          MIN_WORDS  = 64;
	localparam int          DESC_WORDS = 3;
	localparam int          BLK_GAP    = 4;

	// ------------------------------------------------------------
	// descriptor fields and checksum
	// ------------------------------------------------------------
	localparam int          ID_RSV_HI  = 28;
	localparam int          ID_RSV_LO  = 16;
	localparam int          ALIGN_BITS = 3;
	localparam logic [15:0] CRC_INIT   = 16'hFFFF;
	localparam logic [15:0] CRC_POLY   = 16'h1021;

	typedef enum logic [1:0] {
		FVR_IDLE = 2'b00,
		FVR_LOAD = 2'b01,
		FVR_WALK = 2'b11,
		FVR_DONE = 2'b10
	} fvr_state_t;

endpackage

//--- core/fvr_rom_space.sv
// read-only feature and product-data rom space of one adapter
// assumes the adapter streams its stored content in once after reset,
// and the host reads by byte offset from the space base

`timescale 1ns/1ps

module fvr_rom_space #(
	parameter logic [31:0] DEVICE_ID    = 32'h0000_0000, // arbitrary value
	parameter bit          MINIMAL_FORM = 1'b0,
	parameter logic [2:0]  INC_FIELD    = 3'h0,
	parameter logic [1:0]  ROM_IND      = 2'h3,
	parameter logic [15:0] ROM_UNITS    = 16'h0008,
	parameter int          ARCH_N       = 1,
	parameter int          TYPE_N       = 0,
	parameter int          UNIQ_N       = 0
)(
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        rd_req,
	input  wire logic [20:0] rd_addr,
	input  wire logic        wr_req,
	output logic             rd_ready,
	output logic             rd_valid,
	output logic [31:0]      rd_data,
	input  wire logic        ld_valid,
	input  wire logic [31:0] ld_data,
	input  wire logic        ld_last,
	output logic             ld_ready,
	output logic             layout_err
);

	// ------------------------------------------------------------
	// derived sizes
	// ------------------------------------------------------------
	localparam int  OBJ_N   = ARCH_N + TYPE_N + UNIQ_N;
	localparam int  LIMIT   = MINIMAL_FORM ? fvr_pkg::MIN_WORDS
	                                       : int'(ROM_UNITS) * fvr_pkg::UNIT_WORDS;
	localparam int  FW      = $clog2(LIMIT + 1);
	localparam int  AW      = $clog2(LIMIT);
	localparam int  FIRST   = MINIMAL_FORM ? fvr_pkg::MIN_FIRST : fvr_pkg::W_ARRAY;
	localparam int  DBYTES  = (INC_FIELD == fvr_pkg::INC_8) ? 8 : 4;
	localparam int  BLK_MIN = (fvr_pkg::DESC_WORDS * OBJ_N + fvr_pkg::BLK_GAP) * DBYTES;
	localparam int  ARR_END = fvr_pkg::W_ARRAY + fvr_pkg::DESC_WORDS * OBJ_N;
	localparam logic [7:0]    OBJ_N8  = 8'(OBJ_N);
	localparam logic [FW-1:0] FIRST_F = FW'(FIRST);
	localparam logic [FW-1:0] LAST_F  = FW'(LIMIT - 1);
	localparam logic [FW-1:0] ARR_F   = FW'(ARR_END);
	localparam logic [FW-1:0] LIM_F   = FW'(LIMIT);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	generate
		if (INC_FIELD != fvr_pkg::INC_4 && INC_FIELD != fvr_pkg::INC_8)
		begin : g_bad_inc
			$error("increment field must select 4 or 8 byte spacing");
		end
		if (ROM_IND != fvr_pkg::IND_BYTE && ROM_IND != fvr_pkg::IND_WORD)
		begin : g_bad_ind
			$error("rom indicator must be byte or word");
		end
		if (!MINIMAL_FORM && (OBJ_N == 0 || OBJ_N > 255 || ARCH_N < 1 || ARCH_N > 2))
		begin : g_bad_cnt
			$error("object counts out of range");
		end
		if (!MINIMAL_FORM && (ROM_UNITS == 16'h0000 ||
			int'(ROM_UNITS) * fvr_pkg::UNIT_BYTES >= fvr_pkg::SPACE_LEN / DBYTES ||
			ARR_END >= LIMIT))
		begin : g_bad_size
			$error("rom size does not fit the space");
		end
	endgenerate

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	fvr_pkg::fvr_state_t state_r, state_nxt;
	logic [FW-1:0] fill_r, fill_nxt;
	logic [FW-1:0] walk_r, walk_nxt;
	logic [1:0]    ph_r, ph_nxt;
	logic [15:0]   crc_r, crc_nxt;
	logic          err_r, err_nxt;
	logic          rd_valid_r, rd_valid_nxt;
	logic [31:0]   rd_data_r, rd_data_nxt;

	// content words; locations below FIRST are generated, never stored
	logic [31:0]   mem [LIMIT];

	logic          delta8;
	logic          byte_mode;
	logic          rd_take;
	logic          ld_take;
	logic          mem_we;
	logic [20:0]   loc;
	logic          skip;
	logic [20:0]   widx;
	logic [1:0]    lane;
	logic [31:0]   word_v;
	logic [31:0]   rd_val;
	logic [31:0]   walk_word;

	assign delta8    = (INC_FIELD == fvr_pkg::INC_8);
	assign byte_mode = (ROM_IND == fvr_pkg::IND_BYTE);

	// ------------------------------------------------------------
	// crc step over one content word, most significant byte first
	// ------------------------------------------------------------
	function automatic logic [15:0] crc_word(input logic [15:0] c_in, input logic [31:0] d);
		logic [15:0] c;
		logic        fb;
		c  = c_in;
		fb = 1'b0;
		for (int i = 31; i >= 0; i--)
		begin
			fb = c[15] ^ d[i];
			c  = {c[14:0], 1'b0} ^ (fb ? fvr_pkg::CRC_POLY : 16'h0000);
		end
		return c;
	endfunction

	// ------------------------------------------------------------
	// handshakes
	// ------------------------------------------------------------
	// reads wait for the checksum walk so the length word is never stale
	assign rd_ready = (state_r == fvr_pkg::FVR_DONE);
	assign ld_ready = (state_r == fvr_pkg::FVR_IDLE) || (state_r == fvr_pkg::FVR_LOAD);
	assign rd_take  = rd_req && rd_ready;
	assign ld_take  = ld_valid && ld_ready;
	assign mem_we   = ld_take && (fill_r < LIM_F); // surplus words are dropped
	assign rd_valid   = rd_valid_r;
	assign rd_data    = rd_data_r;
	assign layout_err = err_r;

	// ------------------------------------------------------------
	// host read decode
	// ------------------------------------------------------------
	always_comb
	begin
		loc  = delta8 ? (rd_addr >> 3) : (rd_addr >> 2);
		skip = delta8 && rd_addr[2];
		widx = byte_mode ? (loc >> 2) : loc;
		lane = loc[1:0];
		if (widx == fvr_pkg::W_DEVID)
			word_v = DEVICE_ID;
		else if (widx == fvr_pkg::W_CHAR)
			word_v = MINIMAL_FORM ? 32'h0000_0000
			                      : {24'h00_0000, OBJ_N8};
		else if (widx == fvr_pkg::W_LENCRC && !MINIMAL_FORM)
			word_v = {ROM_UNITS, crc_r};
		else if (widx < 21'(fill_r))
			word_v = mem[widx[AW-1:0]];
		else
			word_v = 32'h0000_0000;
		if (skip)
			rd_val = 32'h0000_0000;
		else if (byte_mode)
			rd_val = {24'h00_0000, word_v[8 * (3 - int'(lane)) +: 8]};
		else
			rd_val = word_v;
	end

	// ------------------------------------------------------------
	// content store, filled once by the adapter stream
	// ------------------------------------------------------------
	// the stream carries descriptors and blocks as stored, including
	// any scan header and its linked blocks with their own checksum
	always_ff @(posedge core_clk)
	begin
		if (mem_we)
			mem[fill_r[AW-1:0]] <= ld_data;
	end

	assign walk_word = (walk_r < fill_r) ? mem[walk_r[AW-1:0]] : 32'h0000_0000;

	// ------------------------------------------------------------
	// load, checksum walk and descriptor check
	// ------------------------------------------------------------
	always_comb
	begin
		state_nxt = state_r;
		fill_nxt  = fill_r;
		walk_nxt  = walk_r;
		ph_nxt    = ph_r;
		crc_nxt   = crc_r;
		err_nxt   = err_r;
		unique case (state_r)
			fvr_pkg::FVR_IDLE, fvr_pkg::FVR_LOAD:
			begin
				if (ld_take)
				begin
					state_nxt = fvr_pkg::FVR_LOAD;
					if (mem_we)
						fill_nxt = fill_r + FW'(1);
					if (ld_last)
						state_nxt = MINIMAL_FORM ? fvr_pkg::FVR_DONE : fvr_pkg::FVR_WALK;
				end
			end
			fvr_pkg::FVR_WALK:
			begin
				// padding beyond the stored words enters the residue as zero
				crc_nxt  = crc_word(crc_r, walk_word);
				walk_nxt = walk_r + FW'(1);
				if (walk_r < ARR_F)
				begin
					ph_nxt = (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
					if (ph_r == 2'h0 &&
						walk_word[fvr_pkg::ID_RSV_HI:fvr_pkg::ID_RSV_LO] != 13'h0000)
						err_nxt = 1'b1;
					if (ph_r == 2'h1 &&
						(walk_word[fvr_pkg::ALIGN_BITS-1:0] != 3'h0 ||
						 walk_word < 32'(BLK_MIN)))
						err_nxt = 1'b1;
				end
				if (walk_r == LAST_F)
					state_nxt = fvr_pkg::FVR_DONE;
			end
			fvr_pkg::FVR_DONE:
			begin
				state_nxt = fvr_pkg::FVR_DONE;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= fvr_pkg::FVR_IDLE;
			fill_r  <= FIRST_F;
			walk_r  <= FW'(fvr_pkg::W_ARRAY);
			ph_r    <= 2'h0;
			crc_r   <= fvr_pkg::CRC_INIT;
			err_r   <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			fill_r  <= fill_nxt;
			walk_r  <= walk_nxt;
			ph_r    <= ph_nxt;
			crc_r   <= crc_nxt;
			err_r   <= err_nxt;
		end
	end

	// ------------------------------------------------------------
	// host answer path
	// ------------------------------------------------------------
	// writes change nothing; the data register holds its last answer
	always_comb
	begin
		rd_valid_nxt = rd_take;
		rd_data_nxt  = rd_take ? rd_val : rd_data_r;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rd_valid_r <= 1'b0;
			rd_data_r  <= 32'h0000_0000;
		end
		else
		begin
			rd_valid_r <= rd_valid_nxt;
			rd_data_r  <= rd_data_nxt;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_devid_word: assert property (
		rd_take && !skip && !byte_mode && widx == fvr_pkg::W_DEVID
		|=> rd_valid && rd_data == DEVICE_ID)
		else $error("identity word mismatch");

	a_char_minimal: assert property (
		MINIMAL_FORM && rd_take && !skip && widx == fvr_pkg::W_CHAR
		|=> rd_data == 32'h0000_0000)
		else $error("minimal characteristics word not zero");

	a_char_count: assert property (
		!MINIMAL_FORM && rd_take && !skip && !byte_mode && widx == fvr_pkg::W_CHAR
		|=> rd_data[31:8] == 24'h00_0000 && rd_data[7:0] == OBJ_N8 && rd_data[7:0] != 8'h00)
		else $error("characteristics word wrong");

	a_len_units: assert property (
		!MINIMAL_FORM && rd_take && !skip && !byte_mode && widx == fvr_pkg::W_LENCRC
		|=> rd_data == {ROM_UNITS, $past(crc_r)})
		else $error("length and crc word wrong");

	a_beyond_zero: assert property (
		rd_take && widx >= 21'(LIMIT)
		|=> rd_valid && rd_data == 32'h0000_0000)
		else $error("read beyond rom not zero");

	a_skip_zero: assert property (
		rd_take && delta8 && rd_addr[2]
		|=> rd_data == 32'h0000_0000)
		else $error("skipped word not zero");

	a_byte_narrow: assert property (
		byte_mode && rd_valid |-> rd_data[31:8] == 24'h00_0000)
		else $error("byte location wider than a byte");

	a_write_ignored: assert property (
		wr_req && !rd_req |=> !rd_valid && $stable(rd_data))
		else $error("write changed the answer");

	a_crc_frozen: assert property (
		state_r == fvr_pkg::FVR_DONE |=> $stable(crc_r) [*2])
		else $error("residue moved after walk");

	a_walk_length: assert property (
		state_r == fvr_pkg::FVR_WALK && walk_r == LAST_F
		|=> state_r == fvr_pkg::FVR_DONE && rd_ready)
		else $error("walk did not end at last word");

	// once open, reads stay open until the next reset
	a_ready_held: assert property (
		rd_ready |=> rd_ready)
		else $error("reads closed again without reset");

	a_load_closed: assert property (
		state_r == fvr_pkg::FVR_WALK |-> !ld_ready && !rd_ready)
		else $error("handshake open during checksum walk");

	a_rsv_flagged: assert property (
		state_r == fvr_pkg::FVR_WALK && walk_r < ARR_F && ph_r == 2'h0 &&
		walk_word[fvr_pkg::ID_RSV_HI:fvr_pkg::ID_RSV_LO] != 13'h0000
		|=> layout_err)
		else $error("nonzero reserved descriptor bits not flagged");

	a_align_flagged: assert property (
		state_r == fvr_pkg::FVR_WALK && walk_r < ARR_F && ph_r == 2'h1 &&
		walk_word[fvr_pkg::ALIGN_BITS-1:0] != 3'h0
		|=> layout_err)
		else $error("misaligned block offset not flagged");

	a_err_sticky: assert property (
		layout_err |=> layout_err)
		else $error("layout error dropped without reset");

	a_no_stray_answer: assert property (
		!rd_take |=> !rd_valid)
		else $error("answer without a taken read");

endmodule

//--- verification/fvr_host_model.sv
// host side model: issues single reads into the rom space
// assumes a design that answers one edge after it takes a request
`timescale 1ns/1ps

module fvr_host_model (
	input  wire logic        core_clk,
	input  wire logic        rd_ready,
	input  wire logic        rd_valid,
	input  wire logic [31:0] rd_data,
	output logic             rd_req,
	output logic [20:0]      rd_addr
);
	// ------------------------------------------------------------
	// read cycle
	// ------------------------------------------------------------
	// idle bus at time zero
	initial
	begin
		rd_req  = 1'b0;
		rd_addr = 21'h1F_FFFF;
	end

	// request held until an edge sees ready; gives up after 8 cycles
	task automatic read(input logic [20:0] a, output logic [31:0] d, output logic got);
		int n;
		n = 0;
		@(posedge core_clk);
		#2;
		rd_req  = 1'b1;
		rd_addr = a;
		@(negedge core_clk);
		while (rd_ready !== 1'b1 && n < 8)
		begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		#2;
		got     = rd_valid;
		d       = rd_data;
		rd_req  = 1'b0;
		rd_addr = ~a; // released address never repeats the last one
	endtask
endmodule

//--- verification/fvr_rom_space_test.sv
// self-checking bench: standard word rom and minimal byte rom
// assumes the design's hand-over timing; both duts share the load stream
`timescale 1ns/1ps

module fvr_rom_space_test;
	localparam logic [31:0] DEV_ID = 32'h5A00_0000; // arbitrary value
	localparam logic [31:0] STREAM [8] = '{32'h8000_0001, 32'h0000_0028, 32'h0000_0010,
		32'h4000_0005, 32'h0000_0038, 32'h0000_0008, 32'h1234_5678, 32'hA5A5_0F0F};
	localparam logic [20:0] B_ADDR [5] = '{21'h0, 21'h20, 21'h40, 21'h58, 21'h44};
	localparam logic [31:0] BAD_ID [3] = '{32'h8000_0001, 32'h8000_0001, 32'h8001_0001};
	localparam logic [31:0] BAD_OFF [3] = '{32'h2C, 32'h20, 32'h28};
	logic        core_clk, rst, wr_req, ld_valid, ld_last, got;
	logic [31:0] ld_data, got_d, rd_data, rd_data2;
	logic        rd_req, rd_req2, rd_ready, rd_ready2, rd_valid, rd_valid2;
	logic        ld_ready, ld_ready2, layout_err;
	logic [20:0] rd_addr, rd_addr2;
	logic [31:0] img [128];
	logic [20:0] row_addr [8];
	logic [31:0] row_exp [8];
	logic [31:0] b_exp [5];
	int          miscompares;
	int          total_checks;

	// ------------------------------------------------------------
	// duts and host models
	// ------------------------------------------------------------
	fvr_rom_space #(.DEVICE_ID(DEV_ID), .ROM_UNITS(16'h0001), .TYPE_N(1)) dut (
		.core_clk(core_clk), .rst(rst), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
		.rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .ld_valid(ld_valid),
		.ld_data(ld_data), .ld_last(ld_last), .ld_ready(ld_ready), .layout_err(layout_err));
	// minimal form, 8-byte increment, one byte per location
	fvr_rom_space #(.DEVICE_ID(DEV_ID), .MINIMAL_FORM(1'b1), .INC_FIELD(3'h1),
		.ROM_IND(2'h2)) dut2 (
		.core_clk(core_clk), .rst(rst), .rd_req(rd_req2), .rd_addr(rd_addr2), .wr_req(wr_req),
		.rd_ready(rd_ready2), .rd_valid(rd_valid2), .rd_data(rd_data2), .ld_valid(ld_valid),
		.ld_data(ld_data), .ld_last(ld_last), .ld_ready(ld_ready2), .layout_err());
	fvr_host_model host (.core_clk(core_clk), .rd_ready(rd_ready), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_req(rd_req), .rd_addr(rd_addr));
	fvr_host_model host2 (.core_clk(core_clk), .rd_ready(rd_ready2), .rd_valid(rd_valid2),
		.rd_data(rd_data2), .rd_req(rd_req2), .rd_addr(rd_addr2));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// reset held five cycles; outputs checked while it is asserted
	task automatic do_reset();
		rst = 1'b1;
		@(posedge core_clk);
		#2;
		check("reset outputs", {28'h0, rd_ready, rd_valid, ld_ready, layout_err}, 32'h2);
		repeat (4) @(posedge core_clk);
		#2;
		rst = 1'b0;
	endtask

	task automatic load(input int n);
		for (int k = 0; k < n; k++)
		begin
			ld_valid = 1'b1;
			ld_data  = img[3 + k];
			ld_last  = (k == n - 1);
			@(posedge core_clk);
			#2;
		end
		ld_valid = 1'b0;
		ld_last  = 1'b0;
		ld_data  = 32'hFFFF_FFFF;
	endtask

	// bounded wait for the checksum walk to finish
	task automatic wait_ready();
		int n;
		n = 0;
		while (rd_ready !== 1'b1 && n < 300)
		begin
			@(posedge core_clk);
			#2;
			n++;
		end
		check("rd_ready", {31'h0, rd_ready}, 32'h1);
	endtask

	// bit-serial crc over words 3..127, msb first, unstored words zero
	function automatic logic [15:0] crc_of();
		logic [15:0] c;
		logic        fb;
		c = fvr_pkg::CRC_INIT;
		for (int i = 3; i < 128; i++)
			for (int b = 31; b >= 0; b--)
			begin
				fb = c[15] ^ img[i][b];
				c  = {c[14:0], 1'b0} ^ (fb ? fvr_pkg::CRC_POLY : 16'h0000);
			end
		return c;
	endfunction

	task automatic summarize();
		if (miscompares == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// clock, watchdog, main sequence
	// ------------------------------------------------------------
	initial
	begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// whole run is under a thousand cycles; four thousand means a hang
	initial
	begin
		#100000;
		miscompares++;
		summarize();
	end

	initial
	begin
		miscompares  = 0;
		total_checks = 0;
		{wr_req, ld_valid, ld_last} = 3'h0;
		ld_data = 32'h0;
		img     = '{default: 32'h0};
		for (int k = 0; k < 8; k++)
			img[3 + k] = STREAM[k];
		do_reset();
		load(8);
		check("ld_ready after last", {30'h0, ld_ready, ld_ready2}, 32'h0);
		host.read(21'h00_000C, got_d, got);
		check("read while walking", {31'h0, got}, 32'h0);
		b_exp = '{{24'h0, DEV_ID[31:24]}, 32'h0, 32'h80, 32'h01, 32'h0};
		for (int i = 0; i < 5; i++)
		begin
			host2.read(B_ADDR[i], got_d, got);
			// a missing answer must not pass on stale data
			if (!got)
				got_d = 32'hDEAD_BEEF;
			check($sformatf("byte loc %0d", i), got_d, b_exp[i]);
		end
		wait_ready();
		check("layout_err clean", {31'h0, layout_err}, 32'h0);
		wr_req = 1'b1;
		@(posedge core_clk);
		#2;
		wr_req = 1'b0;
		check("write answered", {31'h0, rd_valid}, 32'h0);
		row_addr = '{21'h0, 21'h4, 21'h8, 21'hC, 21'h18, 21'h28, 21'h1FC, 21'h200};
		row_exp  = '{DEV_ID, 32'h2, {16'h0001, crc_of()}, STREAM[0], STREAM[3], STREAM[7],
			32'h0, 32'h0};
		// rows: identity, count, size and crc, descriptors, block, padding, beyond size
		for (int i = 0; i < 8; i++)
		begin
			host.read(row_addr[i], got_d, got);
			if (!got)
				got_d = 32'hDEAD_BEEF;
			check($sformatf("row %0d", i), got_d, row_exp[i]);
		end
		// reserved bits, misaligned offset and offset inside the array
		for (int i = 0; i < 3; i++)
		begin
			img[3] = BAD_ID[i];
			img[4] = BAD_OFF[i];
			do_reset();
			load(8);
			wait_ready();
			check($sformatf("layout_err bad %0d", i), {31'h0, layout_err}, 32'h1);
		end
		summarize();
	end
endmodule
